// ==== inc/bfpg_pkg.sv ====
// Purpose: Constants and types shared by the fault and output-good supervisor.
// Assumes: One 20 MHz clock, synchronous active-high reset.
// Notes:   Times are given in their own unit and converted to cycles here.
// Notes on behaviour
// R01 - Valley current comparator is looked at only while the low-side gate is on.
// R02 - Over-limit valley current holds off the next cycle until current falls below.
// R03 - Feedback above 120 percent latches high-side off and low-side on.
// R04 - Feedback below 68 percent starts the undervoltage delay counter.
// R05 - Undervoltage lasting 1 ms latches both gates off.
// R06 - Undervoltage detection stays disabled until about 2.2 ms after power-on.
// R07 - Both fault latches clear only while enable is low; outside drives it low.
// R08 - Internal 5 V rail below lockout holds every gate off.
// R09 - Supply lockout does not latch; operation resumes when the rail recovers.
// R10 - Over-temperature trip shuts off the gate drives.
// R11 - Thermal shutdown does not latch; restart when the comparator clears.
// R12 - Output-good evaluation stays inactive until soft-start has completed.
// R13 - Feedback within 16 percent asserts output-good after a 1.2 ms delay.
// R14 - At start-up that delay begins only after 2.2 times soft-start.
// R15 - Feedback outside the window drops output-good after 2 us.
// R16 - Output-good pin is open drain: pulled low when not good.
// R17 - Outside party holds enable high to run; low disables the converter.
// R18 - Soft-start period is a fixed 1.4 ms ramp.
// R19 - All delays are counted on the internal clock; comparators are synchronised.
// R20 - Gate-off conditions beat overvoltage low-side-on, except while overvoltage latched.
package bfpg_pkg;

   localparam int CLK_HZ          = 20_000_000;
   localparam int UV_DELAY_US     = 1000;   // Undervoltage persistence, 1 ms.
   localparam int UV_ENABLE_US    = 2200;   // Undervoltage enable after power-on.
   localparam int SOFT_START_US   = 1400;   // Fixed soft-start ramp.
   localparam int GOOD_BLANK_US   = (SOFT_START_US * 22) / 10; // 2.2 times soft-start.
   localparam int GOOD_DELAY_US   = 1200;   // Output-good qualification.
   localparam int GOOD_DROP_NS    = 2000;   // Output-good drop delay, 2 us.

   // Cycle counts; shortest times round down, none below one.
   localparam int UV_DELAY_CYC    = UV_DELAY_US * (CLK_HZ / 1_000_000);
   localparam int UV_ENABLE_CYC   = UV_ENABLE_US * (CLK_HZ / 1_000_000);
   localparam int SOFT_START_CYC  = SOFT_START_US * (CLK_HZ / 1_000_000);
   localparam int GOOD_BLANK_CYC  = GOOD_BLANK_US * (CLK_HZ / 1_000_000);
   localparam int GOOD_DELAY_CYC  = GOOD_DELAY_US * (CLK_HZ / 1_000_000);
   localparam int GOOD_DROP_CYC   = (GOOD_DROP_NS * (CLK_HZ / 1_000_000)) / 1000;

   localparam int SYNC_WIDTH      = 7;

   // Synchronised comparator results.
   typedef struct packed {
      logic enable;
      logic rail_ok;
      logic over_temp;
      logic overvoltage_trip;
      logic undervoltage_trip;
      logic in_window;
      logic valley_current_limit;
   } bfpg_cmp_t;

   // Gate commands toward the drivers.
   typedef struct packed {
      logic high_side_gate;
      logic low_side_gate;
   } bfpg_gate_t;

   typedef enum logic [3:0] {
      ST_OFF     = 4'b0001,
      ST_SOFT    = 4'b0010,
      ST_BLANK   = 4'b0100,
      ST_RUN     = 4'b1000
   } bfpg_state_t;

endpackage

// ==== verilog/bfpg_sync.sv ====
// Purpose: Three-stage synchroniser with agreement filter for a bus of pin inputs.
// Assumes: Inputs are asynchronous to clock.
// Notes:   A change is taken once stages two and three agree.
`timescale 1ns/100ps
module bfpg_sync
   import bfpg_pkg::*;
#(
   parameter int WIDTH = SYNC_WIDTH
) (
   // Clock and reset.
   input  wire logic             clock,
   input  wire logic             reset,
   // Data.
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] stage1;
   logic [WIDTH-1:0] stage2;
   logic [WIDTH-1:0] stage3;

   // Stage one feeds only stage two, so metastability never reaches logic.
   always_ff @(posedge clock) begin
      if (reset) begin
         stage1 <= '0;
         stage2 <= '0;
         stage3 <= '0;
      end else begin
         stage1 <= async_in;
         stage2 <= stage1;
         stage3 <= stage2;
      end
   end

   // Each bit changes only when stages two and three agree.
   genvar i;
   generate
      for (i = 0; i < WIDTH; i++) begin : g_bit
         always_ff @(posedge clock) begin
            if (reset) begin
               sync_out[i] <= 1'b0;
            end else if (stage2[i] == stage3[i]) begin
               sync_out[i] <= stage3[i];
            end
         end
      end
   endgenerate

endmodule

// ==== verilog/bfpg_supervisor.sv ====
// Purpose: Fault supervisor and delayed output-good for a step-down controller.
// Assumes: Comparator and enable inputs are asynchronous levels; one 20 MHz clock.
// Notes:   Gate commands are requests that the drivers honour; dead time is elsewhere.
`timescale 1ns/100ps
module bfpg_supervisor
   import bfpg_pkg::*;
#(
   parameter int UV_DELAY   = UV_DELAY_CYC,
   parameter int UV_ENABLE  = UV_ENABLE_CYC,
   parameter int SOFT_START = SOFT_START_CYC,
   parameter int GOOD_BLANK = GOOD_BLANK_CYC,
   parameter int GOOD_DELAY = GOOD_DELAY_CYC,
   parameter int GOOD_DROP  = GOOD_DROP_CYC,
   parameter int CW         = 16
) (
   // Clock and reset.
   input  wire logic clock,
   input  wire logic reset,
   // Pin and comparator inputs.
   input  wire logic enable,
   input  wire logic internal_5v_rail_ok,
   input  wire logic over_temp,
   input  wire logic overvoltage_trip,
   input  wire logic undervoltage_trip,
   input  wire logic feedback_sense_in_window,
   input  wire logic valley_current_limit,
   // Requests from the modulator.
   input  wire logic pwm_high_req,
   input  wire logic pwm_low_req,
   // Gate drive commands.
   output bfpg_gate_t gate,
   // Status.
   output logic      soft_start_done,
   output logic      ov_latched,
   output logic      uv_latched,
   output logic      cycle_hold,
   // Open-drain output-good pin.
   input  wire logic output_good_in,
   output logic      output_good_out,
   output logic      output_good_oe
);

   bfpg_cmp_t   cmp;
   bfpg_state_t state;
   bfpg_state_t next_state;
   logic [CW-1:0] seq_cnt;
   logic [CW-1:0] uv_cnt;
   logic [CW-1:0] uv_en_cnt;
   logic [CW-1:0] good_cnt;
   logic          uv_armed;
   logic          output_good;
   logic          shut;
   bfpg_gate_t    next_gate;

   // All comparator and pin inputs are filtered before use.
   bfpg_sync #(.WIDTH(SYNC_WIDTH)) u_sync (
      .clock    (clock),
      .reset    (reset),
      .async_in ({enable, internal_5v_rail_ok, over_temp, overvoltage_trip,
                  undervoltage_trip, feedback_sense_in_window, valley_current_limit}),
      .sync_out (cmp)
   ); // R19

   // Non-latching shut-off: lockout or over-temperature, and enable low.
   assign shut = !cmp.rail_ok || cmp.over_temp || !cmp.enable; // R08 R10 R17

   // Sequencer: soft-start, then output-good blanking, then run.
   always_comb begin
      next_state = state;
      unique case (state)
         ST_OFF:   if (!shut) next_state = ST_SOFT;
         ST_SOFT:  if (shut) next_state = ST_OFF;
                   else if (seq_cnt >= CW'(SOFT_START - 1)) next_state = ST_BLANK; // R18
         ST_BLANK: if (shut) next_state = ST_OFF;
                   else if (seq_cnt >= CW'(GOOD_BLANK - 1)) next_state = ST_RUN; // R14
         ST_RUN:   if (shut) next_state = ST_OFF;
      endcase
   end

   // Auto-restart after lockout or heat because the sequence restarts from off.
   always_ff @(posedge clock) begin
      if (reset) begin
         state <= ST_OFF;
      end else begin
         state <= next_state; // R09 R11
      end
   end

   // Sequence counter runs from the start of soft-start to the end of blanking.
   always_ff @(posedge clock) begin
      if (reset || state == ST_OFF || state == ST_RUN) begin
         seq_cnt <= '0;
      end else begin
         seq_cnt <= seq_cnt + CW'(1);
      end
   end

   assign soft_start_done = (state == ST_BLANK) || (state == ST_RUN); // R12

   // Undervoltage arms 2.2 ms after power-on; power-on is enable with a good rail.
   always_ff @(posedge clock) begin
      if (reset || !cmp.enable || !cmp.rail_ok) begin
         uv_en_cnt <= '0;
         uv_armed  <= 1'b0;
      end else if (uv_en_cnt >= CW'(UV_ENABLE - 1)) begin
         uv_armed  <= 1'b1; // R06
      end else begin
         uv_en_cnt <= uv_en_cnt + CW'(1);
      end
   end

   // Undervoltage delay counter runs while the trip persists.
   always_ff @(posedge clock) begin
      if (reset || !cmp.undervoltage_trip || !uv_armed) begin
         uv_cnt <= '0;
      end else if (uv_cnt < CW'(UV_DELAY)) begin
         uv_cnt <= uv_cnt + CW'(1); // R04
      end
   end

   // Fault latches; enable low clears them, and only that does.
   always_ff @(posedge clock) begin
      if (reset || !cmp.enable) begin
         ov_latched <= 1'b0; // R07
         uv_latched <= 1'b0; // R07
      end else begin
         if (cmp.overvoltage_trip) ov_latched <= 1'b1; // R03
         if (uv_cnt >= CW'(UV_DELAY - 1) && cmp.undervoltage_trip) begin
            uv_latched <= 1'b1; // R05
         end
      end
   end

   // Valley current is judged only while the low-side gate is on.
   always_ff @(posedge clock) begin
      if (reset || shut) begin
         cycle_hold <= 1'b0;
      end else if (gate.low_side_gate && cmp.valley_current_limit) begin
         cycle_hold <= 1'b1; // R01
      end else if (!cmp.valley_current_limit) begin
         cycle_hold <= 1'b0; // R02
      end
   end

   // Gate priority: latched overvoltage wins, then every gate-off cause, then PWM.
   always_comb begin
      next_gate = '0;
      if (ov_latched) begin
         next_gate.low_side_gate = 1'b1; // R03 R20
      end else if (shut || uv_latched || state == ST_OFF) begin
         next_gate = '0; // R08 R10 R05 R20
      end else begin
         next_gate.high_side_gate = pwm_high_req && !pwm_low_req && !cycle_hold; // R02
         next_gate.low_side_gate  = pwm_low_req && !pwm_high_req;
      end
   end

   // Registered so the drivers never see a combinational glitch.
   always_ff @(posedge clock) begin
      if (reset) begin
         gate <= '0;
      end else begin
         gate <= next_gate;
      end
   end

   // Output-good: rise after a qualification delay, fall after a short drop delay.
   // Keyed on the next state, so output-good drops on the same edge as a shutdown.
   always_ff @(posedge clock) begin
      if (reset || next_state != ST_RUN || uv_latched || ov_latched) begin
         good_cnt    <= '0;
         output_good <= 1'b0; // R12
      end else if (output_good == cmp.in_window) begin
         good_cnt <= '0;
      end else if (!output_good && good_cnt >= CW'(GOOD_DELAY - 1)) begin
         output_good <= 1'b1; // R13
         good_cnt    <= '0;
      end else if (output_good && good_cnt >= CW'(GOOD_DROP - 1)) begin
         output_good <= 1'b0; // R15
         good_cnt    <= '0;
      end else begin
         good_cnt <= good_cnt + CW'(1);
      end
   end

   // Open drain: drive low when not good, release when good.
   assign output_good_out = 1'b0; // R16
   assign output_good_oe  = !output_good; // R16

   // Sequencer checks: any shut cause stops the sequence, which restarts from off.
   AST_SHUT_OFF: assert property (@(posedge clock) disable iff (reset) // R08 R10
      shut |=> state == ST_OFF)
      else $error("Sequence kept running through a shut-off cause.");
   AST_RESTART: assert property (@(posedge clock) disable iff (reset) // R09 R11
      (state == ST_OFF && !shut) |=> state == ST_SOFT)
      else $error("Sequence did not restart once the shut-off cause cleared.");
   AST_SEQ_ZERO: assert property (@(posedge clock) disable iff (reset) // R18
      state == ST_OFF |=> seq_cnt == '0)
      else $error("Sequence counter not cleared while off.");
   AST_SOFT_HOLD: assert property (@(posedge clock) disable iff (reset) // R18
      (state == ST_SOFT && !shut && seq_cnt < CW'(SOFT_START - 1)) |=> state == ST_SOFT)
      else $error("Soft-start ended early.");
   AST_SOFT_END: assert property (@(posedge clock) disable iff (reset) // R18
      (state == ST_SOFT && !shut && seq_cnt >= CW'(SOFT_START - 1)) |=> state == ST_BLANK)
      else $error("Soft-start did not end on time.");
   AST_BLANK_HOLD: assert property (@(posedge clock) disable iff (reset) // R14
      (state == ST_BLANK && seq_cnt < CW'(GOOD_BLANK - 1)) |=> state != ST_RUN)
      else $error("Output-good blanking ended early.");
   AST_SSD_OFF: assert property (@(posedge clock) disable iff (reset) // R12
      shut |=> !soft_start_done)
      else $error("Soft-start reported done after a shut-off.");

   // Undervoltage checks: nothing counts before arming, and the latch waits out the delay.
   AST_ARM_DROP: assert property (@(posedge clock) disable iff (reset) // R06
      (!cmp.enable || !cmp.rail_ok) |=> !uv_armed)
      else $error("Undervoltage stayed armed without enable and a good rail.");
   AST_UV_IDLE: assert property (@(posedge clock) disable iff (reset) // R06
      !uv_armed |=> uv_cnt == '0)
      else $error("Undervoltage delay counted before arming.");
   AST_UV_ARM: assert property (@(posedge clock) disable iff (reset) // R06
      $rose(uv_latched) |-> uv_armed)
      else $error("Undervoltage latched before detection was enabled.");
   AST_UV_COUNT: assert property (@(posedge clock) disable iff (reset) // R04
      (uv_armed && cmp.undervoltage_trip && uv_cnt < CW'(UV_DELAY))
         |=> uv_cnt == $past(uv_cnt) + CW'(1))
      else $error("Undervoltage delay did not advance during a trip.");
   AST_UV_LATE: assert property (@(posedge clock) disable iff (reset) // R05
      $rose(uv_latched) |-> $past(uv_cnt) >= CW'(UV_DELAY - 1))
      else $error("Undervoltage latched before the delay ran out.");
   AST_UV_GATES: assert property (@(posedge clock) disable iff (reset) // R05
      (uv_latched && !ov_latched) |=> !gate.high_side_gate && !gate.low_side_gate)
      else $error("Latched undervoltage left a gate on.");

   // Fault latch checks: a trip sets its latch and only enable low clears it.
   AST_OV_SET: assert property (@(posedge clock) disable iff (reset) // R03
      (cmp.overvoltage_trip && cmp.enable) |=> ov_latched)
      else $error("Overvoltage trip did not latch.");
   AST_OV_KEEP: assert property (@(posedge clock) disable iff (reset) // R07
      (ov_latched && cmp.enable) |=> ov_latched)
      else $error("Overvoltage latch dropped while enable high.");
   AST_UV_KEEP: assert property (@(posedge clock) disable iff (reset) // R07
      (uv_latched && cmp.enable) |=> uv_latched)
      else $error("Undervoltage latch dropped while enable high.");
   AST_LATCH_CLEAR: assert property (@(posedge clock) disable iff (reset) // R07
      !cmp.enable |=> !ov_latched && !uv_latched)
      else $error("Fault latch survived enable low.");
   AST_OV_CLEAR: assert property (@(posedge clock) disable iff (reset) // R07
      $fell(ov_latched) |-> !$past(cmp.enable))
      else $error("Overvoltage latch cleared while enable high.");

   // Current limit checks: the comparator counts only while the low side conducts.
   AST_HOLD_SET: assert property (@(posedge clock) disable iff (reset) // R01
      (gate.low_side_gate && cmp.valley_current_limit && !shut) |=> cycle_hold)
      else $error("Valley current over limit did not hold the next cycle.");
   AST_HOLD_IGNORE: assert property (@(posedge clock) disable iff (reset) // R01
      (!gate.low_side_gate && !cycle_hold) |=> !cycle_hold)
      else $error("Current limit judged while the low side was off.");
   AST_HOLD_DROP: assert property (@(posedge clock) disable iff (reset) // R02
      !cmp.valley_current_limit |=> !cycle_hold)
      else $error("Cycle hold stayed after current fell below the limit.");
   AST_HOLD: assert property (@(posedge clock) disable iff (reset) // R02
      cycle_hold |=> !gate.high_side_gate)
      else $error("Cycle started during current limit.");

   // Gate checks: overvoltage keeps the low side on, every other fault keeps both off.
   AST_OV_GATES: assert property (@(posedge clock) disable iff (reset) // R03 R20
      ov_latched |=> (gate.low_side_gate && !gate.high_side_gate))
      else $error("Latched overvoltage did not force the gates.");
   AST_LOCKOUT: assert property (@(posedge clock) disable iff (reset) // R08
      (!cmp.rail_ok && !ov_latched) |=> gate == '0)
      else $error("Gate on during supply lockout.");
   AST_THERMAL: assert property (@(posedge clock) disable iff (reset) // R10
      (cmp.over_temp && !ov_latched) |=> gate == '0)
      else $error("Gate on during over-temperature.");
   AST_OFF_GATES: assert property (@(posedge clock) disable iff (reset) // R20
      (state == ST_OFF && !ov_latched) |=> gate == '0)
      else $error("Gate on while the sequence is off.");
   AST_NO_SHOOT: assert property (@(posedge clock) disable iff (reset) // R20
      !(gate.high_side_gate && gate.low_side_gate))
      else $error("Both gates commanded on together.");

   // Output-good checks. The drop check skips falls forced by shutdown or a latched fault,
   // which take no delay.
   AST_GOOD_ONLY_RUN: assert property (@(posedge clock) disable iff (reset) // R12
      output_good |-> state == ST_RUN)
      else $error("Output-good outside run state.");
   AST_GOOD_FAULT: assert property (@(posedge clock) disable iff (reset) // R12
      (uv_latched || ov_latched) |=> !output_good)
      else $error("Output-good high with a latched fault.");
   AST_GOOD_WAIT: assert property (@(posedge clock) disable iff (reset) // R13
      (!output_good && !cmp.in_window) |=> !output_good)
      else $error("Output-good rose while feedback was outside the window.");
   AST_GOOD_RISE: assert property (@(posedge clock) disable iff (reset) // R13
      $rose(output_good) |-> $past(good_cnt) >= CW'(GOOD_DELAY - 1))
      else $error("Output-good rose before the qualification delay.");
   AST_GOOD_FALL: assert property (@(posedge clock) disable iff (reset) // R15
      ($fell(output_good) && $past(next_state) == ST_RUN && !$past(uv_latched)
         && !$past(ov_latched)) |-> $past(good_cnt) >= CW'(GOOD_DROP - 1))
      else $error("Output-good dropped before the drop delay.");
   AST_GOOD_OD: assert property (@(posedge clock) disable iff (reset) // R16
      output_good_oe == !output_good && output_good_out == 1'b0)
      else $error("Output-good pin drive wrong.");

endmodule

// ==== sim/bfpg_partner.sv ====
// Purpose: Far side of the supervisor: comparators, enable pin and output-good wire.
// Assumes: Feedback is given to the model in percent of reference.
// Notes:   Comparators have no hysteresis, so edges land exactly on the thresholds.
`timescale 1ns/100ps
module bfpg_partner (
   // Commands from the bench.
   input  wire logic       en_cmd,
   input  wire logic       rail_cmd,
   input  wire logic       hot_cmd,
   input  wire logic       cur_cmd,
   input  wire logic [7:0] fb_pct,
   // Lines toward the supervisor.
   output logic            enable,
   output logic            rail_ok,
   output logic            over_temp,
   output logic            ov_trip,
   output logic            uv_trip,
   output logic            in_window,
   output logic            cur_limit,
   // Output-good wire.
   input  wire logic       good_oe,
   output logic            good_level
);
   // Enable is held high to run and dropped low to clear latched faults.
   assign enable = en_cmd;
   assign rail_ok = rail_cmd;
   assign over_temp = hot_cmd;
   // The sense comparator keeps reporting even while the low side is off.
   assign cur_limit = cur_cmd;
   // Feedback comparators at 120, 68 and 84 to 116 percent.
   assign ov_trip = fb_pct > 8'h78;
   assign uv_trip = fb_pct < 8'h44;
   assign in_window = (fb_pct >= 8'h54) && (fb_pct <= 8'h74);
   // The pin has a pull-up, so a released driver reads high.
   assign good_level = good_oe ? 1'b0 : 1'b1;
endmodule

// ==== sim/bfpg_supervisor_tb.sv ====
// Purpose: Self-checking bench for the fault and output-good supervisor.
// Assumes: Counts are shortened by parameters; inputs pass a few sync stages.
// Notes:   Latency checks sample the old value early and the new value late.
`timescale 1ns/100ps
module bfpg_supervisor_tb;
   import bfpg_pkg::*;
   localparam int SS = 30, PB = 66, PD = 25, PDR = 4, UE = 40, UD = 20;
   typedef struct {logic [7:0] m; logic [7:0] e; string s;} bfpg_note_t;
   logic       clock, reset, en_cmd, rail_cmd, hot_cmd, cur_cmd, hreq, lreq;
   logic [7:0] fb_pct;
   logic       enable, rail_ok, over_temp, ov_trip, uv_trip, in_window, cur_limit;
   logic       ssd, ov_l, uv_l, hold, good_in, good_out, good_oe;
   bfpg_gate_t gate;
   int         bad_count, n_tests;
   bit [31:0]  seed = 32'h0000004E;
   bfpg_note_t notes[$];
   bfpg_note_t cur;
   wire [7:0]  obs = {gate, ssd, ov_l, uv_l, hold, good_oe, good_out};

   bfpg_partner far (.en_cmd(en_cmd), .rail_cmd(rail_cmd), .hot_cmd(hot_cmd),
      .cur_cmd(cur_cmd), .fb_pct(fb_pct), .enable(enable), .rail_ok(rail_ok),
      .over_temp(over_temp), .ov_trip(ov_trip), .uv_trip(uv_trip),
      .in_window(in_window), .cur_limit(cur_limit), .good_oe(good_oe),
      .good_level(good_in));

   bfpg_supervisor #(.UV_DELAY(UD), .UV_ENABLE(UE), .SOFT_START(SS), .GOOD_BLANK(PB),
      .GOOD_DELAY(PD), .GOOD_DROP(PDR), .CW(16)) dut (.clock(clock), .reset(reset),
      .enable(enable), .internal_5v_rail_ok(rail_ok), .over_temp(over_temp),
      .overvoltage_trip(ov_trip), .undervoltage_trip(uv_trip),
      .feedback_sense_in_window(in_window), .valley_current_limit(cur_limit),
      .pwm_high_req(hreq), .pwm_low_req(lreq), .gate(gate), .soft_start_done(ssd),
      .ov_latched(ov_l), .uv_latched(uv_l), .cycle_hold(hold), .output_good_in(good_in),
      .output_good_out(good_out), .output_good_oe(good_oe));

   // Half-period toggle gives the 20 MHz clock.
   always #25 clock = ~clock;

   function automatic bit [31:0] xs(input bit [31:0] x);
      x ^= x << 13;
      x ^= x >> 17;
      x ^= x << 5;
      return x;
   endfunction

   task automatic step(input int n);
      repeat (n) @(posedge clock);
   endtask

   task automatic note(input logic [7:0] m, input logic [7:0] e, input string s);
      notes.push_back('{m, e, s});
   endtask

   // Old value is due at lo cycles and the new one by hi cycles.
   task automatic window(input logic [7:0] m, o, e, input int lo, hi, input string s);
      step(lo);
      note(m, o, s);
      step(hi - lo);
      note(m, e, s);
   endtask

   task automatic complete_run();
      if (bad_count == 0 && n_tests > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // Notes are compared on the falling edge, when registered outputs have settled.
   always @(negedge clock) begin
      while (notes.size() != 0) begin
         cur = notes.pop_front();
         n_tests++;
         if ((obs & cur.m) !== cur.e) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", cur.s, cur.e, obs & cur.m);
         end
      end
   end

   // The whole run costs far fewer cycles than this bound.
   initial begin
      step(20000);
      bad_count++;
      complete_run();
   end

   initial begin
      clock = 0;
      reset = 1;
      en_cmd = 0;
      rail_cmd = 1;
      hot_cmd = 0;
      cur_cmd = 0;
      hreq = 0;
      lreq = 0;
      fb_pct = 8'h64;
      step(8);
      reset <= 0;
      step(1);
      note(8'hFF, 8'h02, "reset");
      en_cmd <= 1;
      window(8'h20, 8'h00, 8'h20, SS, SS + 8, "soft_start_done");
      // Soft-start began SS + 3 cycles ago; blanking runs from its start and qualification follows blanking.
      window(8'h03, 8'h02, 8'h00, PB + PD - SS - 8, PB + PD - SS + 2, "oe_rise");
      fb_pct <= 8'h50;
      window(8'h03, 8'h00, 8'h02, PDR, PDR + 9, "oe_drop");
      fb_pct <= 8'h64;
      for (int i = 0; i < 16; i++) begin
         seed = xs(seed);
         hreq <= seed[0];
         lreq <= seed[1];
         step(1);
         note(8'hC0, {seed[0] & ~seed[1], seed[1] & ~seed[0], 6'h00}, "gate");
      end
      hreq <= 0;
      lreq <= 0;
      cur_cmd <= 1;
      step(10);
      note(8'h04, 8'h00, "hold_low_off");
      lreq <= 1;
      window(8'h04, 8'h00, 8'h04, 0, 8, "hold_set");
      lreq <= 0;
      hreq <= 1;
      step(3);
      note(8'hC4, 8'h04, "gate_held");
      hreq <= 0;
      lreq <= 1;
      cur_cmd <= 0;
      window(8'h04, 8'h04, 8'h00, 1, 9, "hold_clear");
      lreq <= 0;
      // Lockout then thermal: both must stop gates and let them resume.
      for (int k = 0; k < 2; k++) begin
         hreq <= 1;
         if (k == 0) begin
            rail_cmd <= 0;
         end else begin
            hot_cmd <= 1;
         end
         window(8'hC0, 8'h80, 8'h00, 1, 8, "gate_off");
         rail_cmd <= 1;
         hot_cmd <= 0;
         window(8'hC0, 8'h00, 8'h80, 2, SS + 12, "gate_back");
      end
      fb_pct <= 8'h82;
      window(8'hD0, 8'h80, 8'h50, 1, 8, "overvoltage");
      fb_pct <= 8'h64;
      rail_cmd <= 0;
      step(10);
      note(8'hD0, 8'h50, "ov_wins");
      en_cmd <= 0;
      rail_cmd <= 1;
      window(8'h10, 8'h10, 8'h00, 1, 8, "ov_clear");
      en_cmd <= 1;
      fb_pct <= 8'h32;
      window(8'h08, 8'h00, 8'h08, UE + UD - 6, UE + UD + 12, "undervoltage");
      step(1);
      note(8'hC0, 8'h00, "uv_gates");
      en_cmd <= 0;
      window(8'h08, 8'h08, 8'h00, 1, 8, "uv_clear");
      step(2);
      complete_run();
   end
endmodule
